// *** include/aofpm_pkg.sv ***
// Constants and types shared by the converter output-stage control logic
package aofpm_pkg;

    // ------------------------------------------------------------
    // Clock and data widths
    // ------------------------------------------------------------
    localparam int CLK_FREQ_MHZ = 25;         // Core clock rate
    localparam int CODE_W = 14;               // Width of one conversion word
    localparam int REG_AW = 4;                // Register address width
    localparam int REG_DW = 8;                // Register data width
    localparam int EVT_W = 4;                 // Number of event bits

    // ------------------------------------------------------------
    // Output code extremes
    // ------------------------------------------------------------
    localparam logic [13:0] OB_MAX = 14'h3fff;   // Offset binary positive full scale
    localparam logic [13:0] OB_MIN = 14'h0000;   // Offset binary negative full scale
    localparam logic [13:0] TC_MAX = 14'h1fff;   // Two's complement positive full scale
    localparam logic [13:0] TC_MIN = 14'h2000;   // Two's complement negative full scale
    localparam logic [13:0] MSB_FLIP = 14'h2000; // Sign-bit mask between the formats
    localparam logic [13:0] OE_ALL_OFF = 14'h3fff; // All data pins released

    // ------------------------------------------------------------
    // Four-level format strap encoding
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_GND = 2'h0;      // Ground
    localparam logic [1:0] MODE_THIRD = 2'h1;    // One third of supply
    localparam logic [1:0] MODE_TWOTHIRD = 2'h2; // Two thirds of supply
    localparam logic [1:0] MODE_SUPPLY = 2'h3;   // Full supply

    // ------------------------------------------------------------
    // Recovery and lock timing
    // ------------------------------------------------------------
    localparam int SLEEP_WAKE_TIME_US = 2000;    // Reference recharge after sleep
    localparam int NAP_WAKE_TIME_NS = 1000;      // Recovery after nap
    localparam int SLEEP_WAKE_CYCLES_DEF = SLEEP_WAKE_TIME_US * CLK_FREQ_MHZ;
    localparam int NAP_WAKE_CYCLES = (NAP_WAKE_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int DCS_LOCK_CYCLES = 100;        // Stabilizer lock time in clocks
    localparam int WAKE_CNT_W = 16;              // Recovery counter width
    localparam int LOCK_CNT_W = 7;               // Lock counter width

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] REG_STATUS = 4'h0;    // Sticky events, write one to clear
    localparam logic [3:0] REG_MASK = 4'h4;      // Interrupt mask
    localparam logic [3:0] REG_STATE = 4'h8;     // Live state readout
    localparam logic [3:0] MASK_RESET = 4'h0;    // Mask reset value

    // Event bit positions
    localparam int EVT_OVERRANGE = 0;
    localparam int EVT_WAKE_DONE = 1;
    localparam int EVT_SLEEP = 2;
    localparam int EVT_LOCKED = 3;

    // State readout bit positions
    localparam int ST_PWR_LO = 0;
    localparam int ST_TWOS = 2;
    localparam int ST_DCS_EN = 3;
    localparam int ST_LOCKED = 4;
    localparam int ST_VALID = 5;

    // Power states
    typedef enum logic [1:0] {
        PWR_NORMAL,
        PWR_NAP,
        PWR_SLEEP
    } aofpm_pwr_e;

endpackage : aofpm_pkg

// *** rtl/aofpm_core.sv ***
// Output format, overrange, output enable and power-state control of the converter
`timescale 1ns/1ps
// What this block does
// - Offset binary: midscale, ones, zeros at extremes
// - Two's complement: offset code, sign bit inverted
// - Overrange flag high outside range, else low
// - Out of range clamps to extreme code
// - Strap low levels offset binary, high two's
// - Stabilizer on only at middle strap levels
// - Output enable high releases all outputs
// - Power-down strap low: convert every clock
// - Strap and enable high: sleep, reference off
// - Strap high, enable low: nap, reference on
// - Nap recovery faster than sleep recovery
// - Stabilizer samples rising edge, ignores falling
module aofpm_core
    import aofpm_pkg::*;
#(
    parameter int SLEEP_WAKE_CYCLES = SLEEP_WAKE_CYCLES_DEF
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Quantizer result, offset binary, with range indications
    input wire logic [13:0] conv_code,
    input wire logic conv_over,
    input wire logic conv_under,
    // Straps and output enable pin
    input wire logic [1:0] mode_level,
    input wire logic output_enable_n,
    input wire logic power_down_strap,
    // Data pins, as output and enable pairs
    output logic [13:0] sample_code,
    output logic [13:0] sample_code_oe_n,
    output logic overrange_flag,
    output logic overrange_flag_oe_n,
    // Power and clock status
    output logic data_valid,
    output logic reference_on,
    output logic converter_on,
    output logic dcs_enable,
    output logic dcs_locked,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Interrupt
    output logic irq
);

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        logic [13:0] code;              // Registered data word
        logic of;                       // Registered overrange flag
        logic [13:0] code_oe_n;         // Data pin enables
        logic of_oe_n;                  // Flag pin enable
        aofpm_pwr_e pwr;                // Power state
        logic ref_on;                   // Reference powered
        logic conv_on;                  // Converting every clock
        logic [15:0] wake_cnt;          // Recovery countdown
        logic valid;                    // Output data valid
        logic twos;                     // Two's complement selected
        logic dcs_en;                   // Stabilizer enabled
        logic [6:0] lock_cnt;           // Stabilizer lock counter
        logic locked;                   // Stabilizer locked
        logic [3:0] status;             // Sticky events
        logic [3:0] mask;               // Interrupt mask
        logic irq;                      // Interrupt level
        logic [7:0] rdata;              // Read data
    } aofpm_state_s;

    aofpm_state_s q;                    // Current state
    aofpm_state_s d;                    // Next state

    // Helper terms of the logic; conv_go and range_any are also used by the checks
    logic conv_go;                      // Conversion happens this edge
    logic range_any;                    // Either end exceeded
    logic [3:0] evt;                    // Events this cycle
    logic [3:0] clr;                    // Status bits cleared by software

    assign range_any = conv_over | conv_under;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        clr = 4'h0;
        evt = 4'h0;

        // Format strap decode
        d.twos = (mode_level == MODE_TWOTHIRD) || (mode_level == MODE_SUPPLY);
        // Stabilizer only at the middle levels; sampling stays on rising edges
        d.dcs_en = (mode_level == MODE_THIRD) || (mode_level == MODE_TWOTHIRD);

        // Power state from strap and enable pin
        if (!power_down_strap) begin
            d.pwr = PWR_NORMAL;
        end else if (output_enable_n) begin
            d.pwr = PWR_SLEEP;
        end else begin
            d.pwr = PWR_NAP;
        end
        conv_go = (d.pwr == PWR_NORMAL);
        // Power indications kept in flops so the pins come straight from state
        d.ref_on = (d.pwr != PWR_SLEEP);
        d.conv_on = conv_go;

        // Recovery countdown, loaded while powered down
        unique case (d.pwr)
            PWR_SLEEP: begin
                d.wake_cnt = WAKE_CNT_W'(SLEEP_WAKE_CYCLES);
            end
            PWR_NAP: begin
                d.wake_cnt = WAKE_CNT_W'(NAP_WAKE_CYCLES);
            end
            PWR_NORMAL: begin
                // Count down toward valid data
                if (q.wake_cnt != 16'h0000) begin
                    d.wake_cnt = q.wake_cnt - 16'h0001;
                end
            end
        endcase
        d.valid = conv_go && (q.wake_cnt == 16'h0000);

        // Conversion word and flag, always from the same sample
        if (conv_go) begin
            d.of = range_any;
            if (conv_over) begin
                // Clamp at positive extreme
                d.code = d.twos ? TC_MAX : OB_MAX;
            end else if (conv_under) begin
                // Clamp at negative extreme
                d.code = d.twos ? TC_MIN : OB_MIN;
            end else if (d.twos) begin
                // Sign bit inverted
                d.code = conv_code ^ MSB_FLIP;
            end else begin
                // Straight offset binary
                d.code = conv_code;
            end
        end

        // Pins released when disabled or powered down
        if (output_enable_n || !conv_go) begin
            d.code_oe_n = OE_ALL_OFF;
            d.of_oe_n = 1'b1;
        end else begin
            d.code_oe_n = 14'h0000;
            d.of_oe_n = 1'b0;
        end

        // Stabilizer lock counter, cleared whenever it is off
        if (!d.dcs_en) begin
            d.lock_cnt = 7'h00;
            d.locked = 1'b0;
        end else if (q.lock_cnt != LOCK_CNT_W'(DCS_LOCK_CYCLES)) begin
            d.lock_cnt = q.lock_cnt + 7'h01;
            d.locked = 1'b0;
        end else begin
            d.locked = 1'b1;
        end

        // Events
        evt[EVT_OVERRANGE] = conv_go && range_any;
        evt[EVT_WAKE_DONE] = d.valid && !q.valid;
        evt[EVT_SLEEP] = (d.pwr == PWR_SLEEP) && (q.pwr != PWR_SLEEP);
        evt[EVT_LOCKED] = d.locked && !q.locked;

        // Register writes
        if (reg_wr && (reg_addr == REG_STATUS)) begin
            clr = reg_wdata[3:0];
        end
        if (reg_wr && (reg_addr == REG_MASK)) begin
            d.mask = reg_wdata[3:0];
        end

        // Set wins over a clear in the same cycle
        d.status = (q.status & ~clr) | evt;
        d.irq = |(d.status & d.mask);

        // Read data stands one cycle only
        d.rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                REG_STATUS: begin
                    d.rdata = {4'h0, q.status};
                end
                REG_MASK: begin
                    d.rdata = {4'h0, q.mask};
                end
                REG_STATE: begin
                    d.rdata = {2'h0, q.valid, q.locked, q.dcs_en, q.twos, q.pwr};
                end
                default: begin
                    d.rdata = 8'h00;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            q <= '{
                code: 14'h0000,
                of: 1'b0,
                code_oe_n: OE_ALL_OFF,
                of_oe_n: 1'b1,
                pwr: PWR_NORMAL,
                ref_on: 1'b1,
                conv_on: 1'b1,
                wake_cnt: 16'h0000,
                valid: 1'b0,
                twos: 1'b0,
                dcs_en: 1'b0,
                lock_cnt: 7'h00,
                locked: 1'b0,
                status: 4'h0,
                mask: MASK_RESET,
                irq: 1'b0,
                rdata: 8'h00
            };
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all from the state register
    // ------------------------------------------------------------
    assign sample_code = q.code;
    assign sample_code_oe_n = q.code_oe_n;
    assign overrange_flag = q.of;
    assign overrange_flag_oe_n = q.of_oe_n;
    assign data_valid = q.valid;
    assign reference_on = q.ref_on;
    assign converter_on = q.conv_on;
    assign dcs_enable = q.dcs_en;
    assign dcs_locked = q.locked;
    assign reg_rdata = q.rdata;
    assign irq = q.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    // Bounds for recovery windows
    localparam int NAP_BOUND = 27;

    // Leaving nap and leaving sleep
    sequence s_nap_exit;
        (q.pwr == PWR_NAP) ##1 (q.pwr == PWR_NORMAL);
    endsequence

    sequence s_sleep_exit;
        (q.pwr == PWR_SLEEP) ##1 (q.pwr == PWR_NORMAL);
    endsequence

    // Plain offset code passes through
    a_offset_pass: assert property (
        conv_go && !range_any && !d.twos |=> sample_code == $past(conv_code))
        else $error("offset binary code not passed through");

    // Two's complement differs only in the sign bit
    a_twos_flip: assert property (
        conv_go && !range_any && d.twos |=> (sample_code ^ $past(conv_code)) == MSB_FLIP)
        else $error("two's complement sign bit wrong");

    // Flag follows range state
    a_flag_range: assert property (
        conv_go |=> overrange_flag == $past(range_any))
        else $error("overrange flag does not follow range");

    // Positive clamp in either format
    a_clamp_high: assert property (
        conv_go && conv_over |=> sample_code == (q.twos ? TC_MAX : OB_MAX))
        else $error("positive clamp code wrong");

    // Negative clamp in either format
    a_clamp_low: assert property (
        conv_go && conv_under && !conv_over |=> sample_code == (q.twos ? TC_MIN : OB_MIN))
        else $error("negative clamp code wrong");

    // Format strap decode
    a_format_strap: assert property (
        ##1 q.twos == $past(mode_level[1]))
        else $error("format strap decode wrong");

    // Stabilizer off at the outer levels
    a_dcs_outer: assert property (
        (mode_level == MODE_GND) || (mode_level == MODE_SUPPLY) |=> !dcs_enable && !dcs_locked)
        else $error("stabilizer on at outer strap level");

    // Enable high releases every pin
    a_oe_release: assert property (
        output_enable_n |=> (sample_code_oe_n == OE_ALL_OFF) && overrange_flag_oe_n)
        else $error("pins driven while output enable high");

    // Normal operation drives and converts
    a_normal_run: assert property (
        !power_down_strap && !output_enable_n |=> converter_on && !overrange_flag_oe_n)
        else $error("normal operation not converting");

    // Sleep drops the reference
    a_sleep_ref: assert property (
        power_down_strap && output_enable_n |=> !reference_on && !converter_on)
        else $error("sleep keeps reference on");

    // Nap keeps the reference, releases pins
    a_nap_ref: assert property (
        power_down_strap && !output_enable_n |=> reference_on && sample_code_oe_n == OE_ALL_OFF)
        else $error("nap state wrong");

    // Nap recovery is quick
    a_nap_wake: assert property (
        s_nap_exit |-> ##[1:NAP_BOUND] (data_valid || power_down_strap))
        else $error("nap recovery too slow");

    // Sleep recovery is not quick
    a_sleep_slow: assert property (
        s_sleep_exit |-> (!data_valid)[*8])
        else $error("sleep recovery too fast");

    // Lock only after the stabilizer has run a while
    a_lock_wait: assert property (
        $rose(dcs_enable) |-> (!dcs_locked)[*8])
        else $error("stabilizer locked too early");

    // Code and flag change in the same edge
    a_same_sample: assert property (
        conv_go && conv_over |=> overrange_flag && sample_code[12:0] == OB_MAX[12:0])
        else $error("code and flag from different samples");

endmodule : aofpm_core

// *** bench/aofpm_capture_model.sv ***
// Capture-side model of the logic that latches the converter's output pins
`timescale 1ns/1ps
module aofpm_capture_model
    import aofpm_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Converter pins, as value and enable pairs
    input wire logic [13:0] sample_code,
    input wire logic [13:0] sample_code_oe_n,
    input wire logic overrange_flag,
    input wire logic overrange_flag_oe_n,
    // Converter status
    input wire logic data_valid,
    input wire logic dcs_enable,
    input wire logic dcs_locked,
    // Last captured word
    output logic [13:0] capt_code,
    output logic capt_flag,
    output logic [15:0] capt_count
);
    logic [13:0] pin_code; // Resolved data lines
    logic pin_flag; // Resolved flag line
    logic [13:0] last_code; // Previous line levels
    logic last_flag; // Previous flag level

    // Released lines float, so show the inverse of the last level
    always_comb begin
        for (int i = 0; i < 14; i++) begin
            pin_code[i] = sample_code_oe_n[i] ? ~last_code[i] : sample_code[i];
        end
        pin_flag = overrange_flag_oe_n ? ~last_flag : overrange_flag;
    end

    // Capture only recovered and driven data, locked when the stabilizer is on
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            last_code <= 14'h0000;
            last_flag <= 1'b0;
            capt_code <= 14'h0000;
            capt_flag <= 1'b0;
            capt_count <= 16'h0000;
        end else begin
            last_code <= pin_code;
            last_flag <= pin_flag;
            // Skip data after wake-up and before stabilizer lock
            if (data_valid && (!dcs_enable || dcs_locked) && sample_code_oe_n == 14'h0000) begin
                capt_code <= pin_code;
                capt_flag <= pin_flag;
                capt_count <= capt_count + 16'h0001;
            end
        end
    end
endmodule : aofpm_capture_model

// *** bench/testbench.sv ***
// Self-checking testbench for the converter output-stage control
`timescale 1ns/1ps
module testbench
    import aofpm_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic core_clk = 1'b0, reset = 1'b1;
    logic [13:0] conv_code = 14'h0000, sample_code, sample_code_oe_n, capt_code;
    logic conv_over = 1'b0, conv_under = 1'b0, output_enable_n = 1'b0, power_down_strap = 1'b0;
    logic [1:0] mode_level = 2'h0;
    logic overrange_flag, overrange_flag_oe_n, data_valid, reference_on, converter_on;
    logic dcs_enable, dcs_locked, reg_wr = 1'b0, reg_rd = 1'b0, irq, capt_flag;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, rd;
    logic [15:0] capt_count, cnt_hold;
    logic [13:0] vec [6] = '{14'h2000, 14'h3fff, 14'h0000, 14'h2001, 14'h1fff, 14'h1555};
    int fail_count = 0, total_checks = 0, nap_t, sleep_t;

    // Clock
    always #20 core_clk = ~core_clk;

    aofpm_core #(.SLEEP_WAKE_CYCLES(40)) DUT (.core_clk(core_clk), .reset(reset),
        .conv_code(conv_code), .conv_over(conv_over), .conv_under(conv_under),
        .mode_level(mode_level), .output_enable_n(output_enable_n),
        .power_down_strap(power_down_strap), .sample_code(sample_code),
        .sample_code_oe_n(sample_code_oe_n), .overrange_flag(overrange_flag),
        .overrange_flag_oe_n(overrange_flag_oe_n), .data_valid(data_valid),
        .reference_on(reference_on), .converter_on(converter_on), .dcs_enable(dcs_enable),
        .dcs_locked(dcs_locked), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

    aofpm_capture_model partner (.core_clk(core_clk), .reset(reset),
        .sample_code(sample_code), .sample_code_oe_n(sample_code_oe_n),
        .overrange_flag(overrange_flag), .overrange_flag_oe_n(overrange_flag_oe_n),
        .data_valid(data_valid), .dcs_enable(dcs_enable), .dcs_locked(dcs_locked),
        .capt_code(capt_code), .capt_flag(capt_flag), .capt_count(capt_count));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // Compare one value, count it, report a difference
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Let n clock edges pass, then settle
    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cycles

    // One register write cycle
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // One register read cycle, data taken in the following cycle
    task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read

    // Present one sample and check the word and flag one cycle later
    task automatic apply(input logic [13:0] c, input logic ov, input logic un);
        logic [13:0] e;
        e = ov ? OB_MAX : (un ? OB_MIN : c);
        if (mode_level >= MODE_TWOTHIRD) e = e ^ MSB_FLIP;
        @(posedge core_clk);
        conv_code <= c;
        conv_over <= ov;
        conv_under <= un;
        cycles(1);
        check({2'b00, sample_code}, {2'b00, e});
        check({15'h0000, overrange_flag}, {15'h0000, ov | un});
    endtask : apply

    // Count cycles until output data are valid again
    task automatic wait_valid(output int n);
        n = 0;
        while (data_valid !== 1'b1 && n < 200) begin
            cycles(1);
            n++;
        end
        check({15'h0000, data_valid}, 16'h0001);
    endtask : wait_valid

    // Verdict and end of run
    task automatic end_of_test();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    // Watchdog
    initial begin
        #400000;
        fail_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        end_of_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        cycles(16);
        check({2'b00, sample_code_oe_n}, {2'b00, OE_ALL_OFF});
        @(posedge core_clk);
        reset <= 1'b0;
        // Every strap level, every code class
        for (int m = 0; m < 4; m++) begin
            @(posedge core_clk);
            mode_level <= m[1:0];
            cycles(3);
            check({15'h0000, dcs_enable}, {15'h0000, m == 1 || m == 2});
            if (m == 1) begin
                cycles(105);
                check({15'h0000, dcs_locked}, 16'h0001);
            end
            for (int v = 0; v < 8; v++) begin
                apply(v < 6 ? vec[v] : 14'h1234, v == 6, v == 7);
            end
            check({2'b00, sample_code_oe_n}, 16'h0000);
        end
        cycles(2);
        check({2'b00, capt_code}, {2'b00, OB_MIN ^ MSB_FLIP});
        check({15'h0000, capt_flag}, 16'h0001);
        check({15'h0000, capt_count != 16'h0000}, 16'h0001);
        // Output enable released while converting
        @(posedge core_clk);
        mode_level <= MODE_GND;
        output_enable_n <= 1'b1;
        cycles(3);
        check({1'b0, overrange_flag_oe_n, sample_code_oe_n}, 16'h7fff);
        @(posedge core_clk);
        power_down_strap <= 1'b1;
        cycles(3);
        check({14'h0000, reference_on, converter_on}, 16'h0000);
        cnt_hold = capt_count;
        @(posedge core_clk);
        power_down_strap <= 1'b0;
        output_enable_n <= 1'b0;
        cycles(3);
        check({15'h0000, data_valid}, 16'h0000);
        check(capt_count, cnt_hold);
        wait_valid(sleep_t);
        // Nap holds the last word with pins released
        apply(14'h2abc, 1'b0, 1'b0);
        @(posedge core_clk);
        power_down_strap <= 1'b1;
        conv_code <= 14'h0111;
        cycles(3);
        check({14'h0000, reference_on, converter_on}, 16'h0002);
        check({1'b0, overrange_flag_oe_n, sample_code_oe_n}, 16'h7fff);
        check({2'b00, sample_code}, 16'h2abc);
        @(posedge core_clk);
        power_down_strap <= 1'b0;
        cycles(3);
        check({15'h0000, data_valid}, 16'h0000);
        wait_valid(nap_t);
        check({15'h0000, sleep_t > nap_t}, 16'h0001);
        // Registers and interrupt
        reg_read(REG_MASK, rd);
        check({8'h00, rd}, {12'h000, MASK_RESET});
        reg_write(REG_STATUS, 8'h0f);
        reg_read(REG_STATUS, rd);
        check({15'h0000, rd[EVT_OVERRANGE]}, 16'h0000);
        apply(14'h0000, 1'b1, 1'b0);
        apply(14'h0100, 1'b0, 1'b0);
        reg_read(REG_STATUS, rd);
        check({15'h0000, rd[EVT_OVERRANGE]}, 16'h0001);
        cycles(1);
        check({8'h00, reg_rdata}, 16'h0000);
        check({15'h0000, irq}, 16'h0000);
        reg_write(REG_MASK, 8'h01);
        reg_read(REG_MASK, rd);
        check({8'h00, rd}, 16'h0001);
        cycles(2);
        check({15'h0000, irq}, 16'h0001);
        reg_write(REG_STATUS, 8'h01);
        cycles(2);
        check({15'h0000, irq}, 16'h0000);
        reg_read(4'h2, rd);
        check({8'h00, rd}, 16'h0000);
        end_of_test();
    end
endmodule : testbench
